// File: rtl/aics_clock_select.v
// Audio interface clock source selection and rate reference logic with AXI4-Lite registers
//
// Summary of operation
// RULE_01: DAC1 from receiver: pair mode 0 uses subframe clock, DACs 2-4 off; 1 uses primary rx.
// RULE_02: ADC clock field: 00 ADC pin, 01 PLL A, 10 PLL B, 11 master pin; reset 00.
// RULE_03: With receiver powered, PLL choices for the ADC fall back to the ADC pin.
// RULE_04: Primary transmit carrying ADC data makes primary tx frame clock the ADC reference.
// RULE_05: Else secondary transmit carrying ADC data makes secondary frame clock the reference.
// RULE_06: Only S/PDIF tx on ADC: oversample field sets rate, 128..1152 fs; reset 010.
// RULE_07: S/PDIF tx clock field: 00 ADC pin, 01 PLL A, 10 PLL B, 11 master; reset 01.
// RULE_08: Receiver always on PLL A; tx routed from receiver is forced onto PLL A.
// RULE_09: S/PDIF tx rate reference follows its data source, ADC via primary tx or ratio.
// RULE_10: Master mode ports generate frame and bit clocks internally; slave takes them outside.
// RULE_11: Primary rx master clock: 00 and 11 master pin, 01 PLL A, 10 PLL B; reset 00.
// RULE_12: Primary tx master clock is PLL A for receiver data, else the ADC clock.
// RULE_13: Software should run primary transmit in master mode when carrying receiver data.
// RULE_14: Primary tx slave with ADC on master pin uses the primary rx bit clock.
// RULE_15: Secondary transmit and receive share one frame clock and one bit clock.
// RULE_16: Secondary master clock: 00 ADC pin, 01 PLL A, 10 PLL B, 11 master; reset 11.
// RULE_17: Secondary transmit carrying receiver data forces PLL A as its master clock.
// RULE_18: Otherwise, with receiver powered, secondary PLL choices fall back to the ADC pin.
// RULE_19: Manual override bit 6 disables all automatic restrictions; reset clear.
// RULE_20: Software should keep clock sources synchronous; an independent ADC clock may degrade.
// RULE_21: DAC1 source: 00 receiver, 10 secondary rx, 11 primary rx; reset 11.
// RULE_22: S/PDIF tx source: 00 receiver, 01 ADC, 10 secondary rx, 11 primary rx; reset 00.
// RULE_23: Every clock mux switch is glitch free, never a shortened pulse.
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "aics_map.vh"

module aics_clock_select #(
  parameter ADDR_W = 8
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  output wire [11:0]       mux_sel,
  output wire [5:0]        mux_en,
  output reg  [1:0]        spdif_rx_clock_sel,
  output reg  [2:0]        dac_rate_ref,
  output reg               dacs234_power_down,
  output reg  [2:0]        adc_rate_ref,
  output reg  [2:0]        spdif_tx_rate_ref,
  output reg  [10:0]       adc_rate_ratio,
  output reg               primary_rx_gen_en,
  output reg               primary_tx_gen_en,
  output reg               secondary_gen_en,
  output reg               primary_tx_bclk_from_rx
);

  // Mux dead time in cycles, rounded up, never below one
  localparam integer GAP_RAW = (`AICS_GAP_NS * `AICS_CLK_MHZ + 999) / 1000;
  localparam [3:0]   GAP     = (GAP_RAW < 1) ? 4'h1 : GAP_RAW[3:0];
  localparam integer NMUX    = 6;
  // One-hot switch states
  localparam [2:0] S_RUN = 3'h1;
  localparam [2:0] S_OFF = 3'h2;
  localparam [2:0] S_ON  = 3'h4;

  // Register slot decode; 15 means unmapped
  function [3:0] slot;
    input [5:0] idx;
    begin
      case (idx)
        `AICS_IDX_CKSRC:    slot = 4'h0;
        `AICS_IDX_PRX_CLK:  slot = 4'h1;
        `AICS_IDX_SEC_CLK:  slot = 4'h2;
        `AICS_IDX_DAC_CLK:  slot = 4'h3;
        `AICS_IDX_ADC_CTL1: slot = 4'h4;
        `AICS_IDX_DAC1_SRC: slot = 4'h5;
        `AICS_IDX_PTX_SRC:  slot = 4'h6;
        `AICS_IDX_STX_SRC:  slot = 4'h7;
        `AICS_IDX_SPTX_SRC: slot = 4'h8;
        `AICS_IDX_PORT_CTL: slot = 4'h9;
        `AICS_IDX_STATUS:   slot = 4'hA;
        default:            slot = 4'hF;
      endcase
    end
  endfunction

  // Oversample code to fs multiple; unused code gives zero
  function [10:0] osr_fs;
    input [2:0] code;
    begin
      case (code)
        3'h0:    osr_fs = 11'h080;
        3'h1:    osr_fs = 11'h0C0;
        3'h2:    osr_fs = 11'h100;
        3'h3:    osr_fs = 11'h180;
        3'h4:    osr_fs = 11'h200;
        3'h5:    osr_fs = 11'h300;
        3'h6:    osr_fs = 11'h480;
        default: osr_fs = 11'h000;
      endcase
    end
  endfunction

  // Field where 00 and 11 both mean the master pin
  function [1:0] mclk_field;
    input [1:0] f;
    begin
      mclk_field = (f == 2'h0) ? `AICS_CK_MCLK : f;
    end
  endfunction

  // PLL choice falls back to the ADC pin while the receiver owns the PLLs
  function [1:0] no_pll;
    input [1:0] f;
    input       limit;
    begin
      if (limit && (f == `AICS_CK_PLLA || f == `AICS_CK_PLLB))
        no_pll = `AICS_CK_ADCM;
      else
        no_pll = f;
    end
  endfunction

  reg  [8:0]        regs [0:9];
  reg               aw_full_reg;
  reg [ADDR_W-1:0]  aw_addr_reg;
  reg               w_full_reg;
  reg [31:0]        w_data_reg;
  reg [3:0]         w_strb_reg;
  reg [1:0]         want [0:NMUX-1];
  reg [1:0]         cur_reg [0:NMUX-1];
  reg [2:0]         st_reg [0:NMUX-1];
  reg [3:0]         cnt_reg [0:NMUX-1];
  reg [5:0]         en_reg;
  reg [8:0]         rd_val;
  reg [8:0]         status;
  integer           i;

  wire [3:0] wslot    = slot(aw_addr_reg[7:2]);
  wire [3:0] rslot    = slot(s_axi_araddr[7:2]);
  wire       do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
  wire       manual   = regs[0][`AICS_B_MANUAL];
  wire       rx_power = regs[9][`AICS_B_RX_POWER];
  wire       auto_on  = !manual;                                      // RULE_19
  wire [1:0] dac1_src = regs[5][`AICS_F_SRC_HI];
  wire [1:0] ptx_src  = regs[6][`AICS_F_SRC_HI];
  wire [1:0] stx_src  = regs[7][`AICS_F_SRC_HI];
  wire [1:0] sptx_src = regs[8][`AICS_F_SPTX_SRC];
  wire       dac1_rx  = (dac1_src == `AICS_SRC_RX);
  wire       ptx_adc  = (ptx_src == `AICS_SRC_ADC);
  wire       stx_adc  = (stx_src == `AICS_SRC_ADC);

  // Handshake outputs; one write and one read in flight
  assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // Write channel capture, register update and response
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg  <= 1'b0;
      aw_addr_reg  <= {ADDR_W{1'b0}};
      w_full_reg   <= 1'b0;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `AICS_RESP_OKAY;
      regs[0] <= `AICS_RST_CKSRC;                                    // RULE_02 RULE_07 RULE_19
      regs[1] <= `AICS_RST_PRX_CLK;                                  // RULE_11
      regs[2] <= `AICS_RST_SEC_CLK;                                  // RULE_16
      regs[3] <= `AICS_RST_DAC_CLK;
      regs[4] <= `AICS_RST_ADC_CTL1;                                 // RULE_06
      regs[5] <= `AICS_RST_DAC1_SRC;                                 // RULE_21
      regs[6] <= `AICS_RST_PTX_SRC;
      regs[7] <= `AICS_RST_STX_SRC;
      regs[8] <= `AICS_RST_SPTX_SRC;                                 // RULE_22
      regs[9] <= `AICS_RST_PORT_CTL;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      // Status is read only: writes to it are accepted and dropped
      if (do_write) begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wslot == 4'hF) ? `AICS_RESP_SLVERR : `AICS_RESP_OKAY;
        if (wslot < 4'hA) begin
          if (w_strb_reg[0])
            regs[wslot][7:0] <= w_data_reg[7:0];
          if (w_strb_reg[1])
            regs[wslot][8] <= w_data_reg[8];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read data mux
  always @* begin
    case (rslot)
      4'hA:    rd_val = status;
      4'hF:    rd_val = 9'h000;
      default: rd_val = regs[rslot[3:0]];
    endcase
  end

  // Read channel, answered one cycle after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `AICS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {23'h000000, rd_val};
      s_axi_rresp  <= (rslot == 4'hF) ? `AICS_RESP_SLVERR : `AICS_RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Wanted source of each mux: 0 DAC, 1 ADC, 2 S/PDIF tx, 3 pri rx, 4 pri tx, 5 secondary
  always @* begin
    want[0] = mclk_field(regs[0][`AICS_F_DAC_CLK]);
    if (auto_on && dac1_rx)
      want[0] = `AICS_CK_PLLA;
    want[1] = no_pll(regs[0][`AICS_F_ADC_CLK], auto_on && rx_power);  // RULE_02 RULE_03
    want[2] = regs[0][`AICS_F_SPTX_CLK];                               // RULE_07
    if (auto_on && sptx_src == `AICS_SRC_RX)
      want[2] = `AICS_CK_PLLA;                                         // RULE_08
    want[3] = mclk_field(regs[1][`AICS_F_MM_CLK]);                     // RULE_11
    // Primary tx master clock tracks the ADC clock after its own restriction
    want[4] = want[1];                                                 // RULE_12
    if (auto_on && ptx_src == `AICS_SRC_RX)
      want[4] = `AICS_CK_PLLA;                                         // RULE_12
    // One selection feeds the generator shared by both secondary directions
    if (auto_on && stx_src == `AICS_SRC_RX)
      want[5] = `AICS_CK_PLLA;                                         // RULE_17
    else
      want[5] = no_pll(regs[2][`AICS_F_MM_CLK], auto_on && rx_power);  // RULE_16 RULE_18
  end

  // Break before make: gate the clock, wait, switch, wait, ungate.
  // Costs a short clock gap on every change but never a runt pulse.
  always @(posedge aclk) begin
    for (i = 0; i < NMUX; i = i + 1) begin
      if (!aresetn) begin
        st_reg[i]  <= S_OFF;
        cnt_reg[i] <= GAP;
        cur_reg[i] <= `AICS_CK_ADCM;
        en_reg[i]  <= 1'b0;
      end else begin
        case (st_reg[i])
          S_RUN: begin
            if (want[i] != cur_reg[i]) begin
              en_reg[i]  <= 1'b0;                                      // RULE_23
              cnt_reg[i] <= GAP;
              st_reg[i]  <= S_OFF;
            end
          end
          S_OFF: begin
            if (cnt_reg[i] > 4'h1) begin
              cnt_reg[i] <= cnt_reg[i] - 4'h1;
            end else begin
              cur_reg[i] <= want[i];                                   // RULE_23
              cnt_reg[i] <= GAP;
              st_reg[i]  <= S_ON;
            end
          end
          S_ON: begin
            if (want[i] != cur_reg[i]) begin
              cnt_reg[i] <= GAP;
              st_reg[i]  <= S_OFF;
            end else if (cnt_reg[i] > 4'h1) begin
              cnt_reg[i] <= cnt_reg[i] - 4'h1;
            end else begin
              en_reg[i] <= 1'b1;                                       // RULE_23
              st_reg[i] <= S_RUN;
            end
          end
          default: begin
            en_reg[i] <= 1'b0;
            st_reg[i] <= S_OFF;
            cnt_reg[i] <= GAP;
          end
        endcase
      end
    end
  end

  assign mux_en  = en_reg;
  assign mux_sel = {cur_reg[5], cur_reg[4], cur_reg[3], cur_reg[2], cur_reg[1], cur_reg[0]};

  // Effective selections as seen by software
  always @* begin
    status = {dacs234_power_down, cur_reg[4], cur_reg[5], cur_reg[2], cur_reg[1]};
  end

  // Rate references, power down and generator enables
  always @(posedge aclk) begin
    if (!aresetn) begin
      spdif_rx_clock_sel      <= `AICS_CK_PLLA;
      dac_rate_ref            <= `AICS_REF_PRX;
      dacs234_power_down      <= 1'b0;
      adc_rate_ref            <= `AICS_REF_PTX;
      spdif_tx_rate_ref       <= `AICS_REF_SFRM;
      adc_rate_ratio          <= 11'h000;
      primary_rx_gen_en       <= 1'b0;
      primary_tx_gen_en       <= 1'b0;
      secondary_gen_en        <= 1'b0;
      primary_tx_bclk_from_rx <= 1'b0;
    end else begin
      spdif_rx_clock_sel <= `AICS_CK_PLLA;                             // RULE_08
      // DAC reference by DAC1 routing
      if (dac1_rx) begin
        dac_rate_ref       <= regs[3][`AICS_B_PAIR_MODE] ? `AICS_REF_PRX
                                                         : `AICS_REF_SFRM; // RULE_01
        dacs234_power_down <= !regs[3][`AICS_B_PAIR_MODE];            // RULE_01
      end else begin
        dac_rate_ref       <= (dac1_src == `AICS_SRC_SEC) ? `AICS_REF_SEC
                                                         : `AICS_REF_PRX; // RULE_21
        dacs234_power_down <= 1'b0;
      end
      // ADC reference: primary tx first, then secondary, else ratio
      if (ptx_adc)
        adc_rate_ref <= `AICS_REF_PTX;                                 // RULE_04
      else if (stx_adc)
        adc_rate_ref <= `AICS_REF_SEC;                                 // RULE_05
      else
        adc_rate_ref <= `AICS_REF_RATIO;                               // RULE_06
      adc_rate_ratio <= osr_fs(regs[4][`AICS_F_OSR]);                  // RULE_06
      // S/PDIF transmitter reference by its data source
      case (sptx_src)
        `AICS_SRC_RX:  spdif_tx_rate_ref <= `AICS_REF_SFRM;            // RULE_09
        `AICS_SRC_PRI: spdif_tx_rate_ref <= `AICS_REF_PRX;             // RULE_09
        `AICS_SRC_SEC: spdif_tx_rate_ref <= `AICS_REF_SRX;             // RULE_09
        default:       spdif_tx_rate_ref <= ptx_adc ? `AICS_REF_PTX
                                                    : `AICS_REF_RATIO; // RULE_09
      endcase
      // Generators run only in master mode and only on a settled clock
      primary_rx_gen_en <= regs[9][`AICS_B_PRX_MASTER] && en_reg[3];   // RULE_10
      primary_tx_gen_en <= regs[9][`AICS_B_PTX_MASTER] && en_reg[4];   // RULE_10
      secondary_gen_en  <= regs[9][`AICS_B_SEC_MASTER] && en_reg[5];   // RULE_10 RULE_15
      primary_tx_bclk_from_rx <= !regs[9][`AICS_B_PTX_MASTER]
                                 && (cur_reg[1] == `AICS_CK_MCLK);     // RULE_14
    end
  end

endmodule

// File: rtl/aics_map.vh
// Register indices, field positions, reset values and codes of the clock select block
`ifndef AICS_MAP_VH
`define AICS_MAP_VH
// Register indices; the byte address is four times the index
`define AICS_IDX_CKSRC     6'h08
`define AICS_IDX_PRX_CLK   6'h09
`define AICS_IDX_SEC_CLK   6'h0B
`define AICS_IDX_DAC_CLK   6'h0F
`define AICS_IDX_ADC_CTL1  6'h1D
`define AICS_IDX_DAC1_SRC  6'h0C
`define AICS_IDX_PTX_SRC   6'h0D
`define AICS_IDX_STX_SRC   6'h0E
`define AICS_IDX_SPTX_SRC  6'h1E
`define AICS_IDX_PORT_CTL  6'h20
`define AICS_IDX_STATUS    6'h21
// Reset values
`define AICS_RST_CKSRC     9'h010
`define AICS_RST_PRX_CLK   9'h000
`define AICS_RST_SEC_CLK   9'h0C0
`define AICS_RST_DAC_CLK   9'h000
`define AICS_RST_ADC_CTL1  9'h040
`define AICS_RST_DAC1_SRC  9'h180
`define AICS_RST_PTX_SRC   9'h080
`define AICS_RST_STX_SRC   9'h000
`define AICS_RST_SPTX_SRC  9'h000
`define AICS_RST_PORT_CTL  9'h000
// Field positions
`define AICS_F_DAC_CLK     1:0
`define AICS_F_ADC_CLK     3:2
`define AICS_F_SPTX_CLK    5:4
`define AICS_B_MANUAL      6
`define AICS_F_MM_CLK      7:6
`define AICS_B_PAIR_MODE   8
`define AICS_F_OSR         7:5
`define AICS_F_SRC_HI      8:7
`define AICS_F_SPTX_SRC    1:0
`define AICS_B_RX_POWER    0
`define AICS_B_PRX_MASTER  1
`define AICS_B_PTX_MASTER  2
`define AICS_B_SEC_MASTER  3
// Clock source codes on the mux select outputs
`define AICS_CK_ADCM       2'h0
`define AICS_CK_PLLA       2'h1
`define AICS_CK_PLLB       2'h2
`define AICS_CK_MCLK       2'h3
// Routing source codes
`define AICS_SRC_RX        2'h0
`define AICS_SRC_ADC       2'h1
`define AICS_SRC_SEC       2'h2
`define AICS_SRC_PRI       2'h3
// Rate reference codes
`define AICS_REF_SFRM      3'h0
`define AICS_REF_PRX       3'h1
`define AICS_REF_PTX       3'h2
`define AICS_REF_SEC       3'h3
`define AICS_REF_SRX       3'h4
`define AICS_REF_RATIO     3'h5
// Bus responses
`define AICS_RESP_OKAY     2'h0
`define AICS_RESP_SLVERR   2'h2
// Clock mux dead time
`define AICS_GAP_NS        400
`define AICS_CLK_MHZ       10
`endif

// File: tb/aics_checker.sv
// Port-level assertions for the clock select block
`timescale 1ns/1ps
`include "aics_map.vh"
module aics_checker (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awready,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [11:0] mux_sel,
  input wire [5:0]  mux_en,
  input wire [1:0]  spdif_rx_clock_sel,
  input wire [10:0] adc_rate_ratio,
  input wire        primary_rx_gen_en,
  input wire        secondary_gen_en,
  input wire        primary_tx_bclk_from_rx
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  reg [11:0] sel_d_reg;
  reg [5:0]  en_d_reg;
  reg [5:0]  glitch;
  integer    i;
  // Last cycle's mux state; a select moving under an open gate would cut a pulse short
  always @(posedge aclk) begin
    sel_d_reg <= mux_sel;
    en_d_reg <= mux_en;
  end
  always @* begin
    for (i = 0; i < 6; i = i + 1) begin
      glitch[i] = en_d_reg[i] & mux_en[i] & (sel_d_reg[2*i +: 2] != mux_sel[2*i +: 2]);
    end
  end
  a_mux_quiet_gate: assert property (glitch == 6'h00)
    else $error("mux select moved while its gate was open");
  a_sel_after_gap: assert property ($changed(mux_sel[3:2]) |-> !mux_en[1] && !$past(mux_en[1], 4))
    else $error("ADC mux select changed without the off gap");
  a_rx_on_plla: assert property (spdif_rx_clock_sel == `AICS_CK_PLLA)
    else $error("receiver clock is not PLL A");
  a_prx_gen_gate: assert property (primary_rx_gen_en |-> $past(mux_en[3]))
    else $error("primary rx generator ran on a gated clock");
  a_sec_gen_gate: assert property (secondary_gen_en |-> $past(mux_en[5]))
    else $error("secondary generator ran on a gated clock");
  a_bclk_master_pin: assert property (primary_tx_bclk_from_rx |->
    (mux_sel[3:2] == `AICS_CK_MCLK || $past(mux_sel[3:2]) == `AICS_CK_MCLK))
    else $error("bit clock borrowed while ADC clock is not the master pin");
  a_ratio_legal: assert property ($past(aresetn) |-> adc_rate_ratio inside {11'h080, 11'h0C0, 11'h100,
    11'h180, 11'h200, 11'h300, 11'h480})
    else $error("ADC ratio outside the table");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_read_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:9] == 23'h0)
    else $error("read answer late or wide");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write taken during response");
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == `AICS_RESP_SLVERR);
  c_adc_switch: cover property ($rose(mux_en[1]));
  c_bclk_borrow: cover property (primary_tx_bclk_from_rx);
  c_sec_gen: cover property (secondary_gen_en);
endmodule

bind aics_clock_select aics_checker i_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .mux_sel(mux_sel), .mux_en(mux_en),
  .spdif_rx_clock_sel(spdif_rx_clock_sel), .adc_rate_ratio(adc_rate_ratio),
  .primary_rx_gen_en(primary_rx_gen_en), .secondary_gen_en(secondary_gen_en),
  .primary_tx_bclk_from_rx(primary_tx_bclk_from_rx)
);

// File: tb/tb_aics_clock_select.sv
// Self-checking bench for the clock select block
`timescale 1ns/1ps
`include "aics_map.vh"
module tb_aics_clock_select;
  reg         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  reg  [7:0]  awaddr, araddr;
  reg  [31:0] wdata;
  reg  [3:0]  wstrb;
  wire        awready, wready, bvalid, arready, rvalid, pd, prx_gen, ptx_gen, sec_gen, bclk_rx;
  wire [1:0]  bresp, rresp, rxsel;
  wire [31:0] rdata;
  wire [11:0] sel;
  wire [5:0]  en;
  wire [2:0]  dref, aref, tref;
  wire [10:0] ratio;
  integer     n_fail, total_checks, cyc, k;
  localparam [1:0]  OK = `AICS_RESP_OKAY;
  localparam [1:0]  ERR = `AICS_RESP_SLVERR;
  localparam [7:0]  A_CLK = {`AICS_IDX_CKSRC, 2'b00};
  localparam [7:0]  A_PRX = {`AICS_IDX_PRX_CLK, 2'b00};
  localparam [7:0]  A_SEC = {`AICS_IDX_SEC_CLK, 2'b00};
  localparam [7:0]  A_DCK = {`AICS_IDX_DAC_CLK, 2'b00};
  localparam [7:0]  A_ADC = {`AICS_IDX_ADC_CTL1, 2'b00};
  localparam [7:0]  A_DSRC = {`AICS_IDX_DAC1_SRC, 2'b00};
  localparam [7:0]  A_PSRC = {`AICS_IDX_PTX_SRC, 2'b00};
  localparam [7:0]  A_SSRC = {`AICS_IDX_STX_SRC, 2'b00};
  localparam [7:0]  A_TSRC = {`AICS_IDX_SPTX_SRC, 2'b00};
  localparam [7:0]  A_PORT = {`AICS_IDX_PORT_CTL, 2'b00};
  localparam [7:0]  A_STAT = {`AICS_IDX_STATUS, 2'b00};
  localparam [76:0] RATIOS = {11'h480, 11'h300, 11'h200, 11'h180, 11'h100, 11'h0C0, 11'h080};
  // S/PDIF tx reference per source code while the primary tx carries ADC data
  localparam [11:0] TREFS = {`AICS_REF_PRX, `AICS_REF_SRX, `AICS_REF_PTX, `AICS_REF_SFRM};

  aics_clock_select #(.ADDR_W(8)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .mux_sel(sel), .mux_en(en), .spdif_rx_clock_sel(rxsel), .dac_rate_ref(dref),
    .dacs234_power_down(pd), .adc_rate_ref(aref), .spdif_tx_rate_ref(tref),
    .adc_rate_ratio(ratio), .primary_rx_gen_en(prx_gen), .primary_tx_gen_en(ptx_gen),
    .secondary_gen_en(sec_gen), .primary_tx_bclk_from_rx(bclk_rx)
  );

  // One 10 MHz clock for all; the hang guard is far above the run
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      end_sim;
    end
  end

  task end_sim;
    begin
      $display("Checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  task check(input [31:0] seen, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  // Ready and valid are judged at the falling edge so the rising edge sees settled values
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    reg ta, tw, done;
    begin
      done = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done) begin
        @(negedge aclk);
        ta = awvalid & awready;
        tw = wvalid & wready;
        done = bvalid;
        if (done) check(bresp, er);
        @(posedge aclk);
        if (ta) awvalid <= 1'b0;
        if (tw) wvalid <= 1'b0;
        if (done) bready <= 1'b0;
      end
    end
  endtask

  task rd(input [7:0] a, input [31:0] ed, input [1:0] er);
    reg t, done;
    begin
      done = 1'b0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done) begin
        @(negedge aclk);
        t = arvalid & arready;
        done = rvalid;
        if (done) check(rdata, ed);
        if (done) check(rresp, er);
        @(posedge aclk);
        if (t) arvalid <= 1'b0;
        if (done) rready <= 1'b0;
      end
    end
  endtask

  // A mux switch takes two gaps of four cycles; twelve leaves margin
  task settle;
    repeat (12) @(negedge aclk);
  endtask

  task t_reset;
    begin
      rd(A_CLK, 32'h010, OK);
      rd(A_PRX, 32'h000, OK);
      rd(A_SEC, 32'h0C0, OK);
      rd(A_DCK, 32'h000, OK);
      rd(A_ADC, 32'h040, OK);
      rd(A_DSRC, 32'h180, OK);
      rd(A_TSRC, 32'h000, OK);
      settle;
      check(sel, 12'h4D3);
      check(en, 6'h3F);
      check(ratio, 11'h100);
      check(dref, `AICS_REF_PRX);
      check(aref, `AICS_REF_PTX);
      check(tref, `AICS_REF_SFRM);
    end
  endtask

  task t_adc;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        wr(A_CLK, 32'h010 | (k << 2), OK);
        @(negedge aclk);
        check(en[1], k == 0);
        settle;
        check(sel[3:2], k);
        check(sel[9:8], k);
        check(bclk_rx, k == 3);
      end
      wr(A_PORT, 32'h001, OK);
      wr(A_CLK, 32'h014, OK);
      wr(A_SEC, 32'h080, OK);
      wr(A_SSRC, 32'h080, OK);
      settle;
      check(sel[3:2], `AICS_CK_ADCM);
      check(sel[11:10], `AICS_CK_ADCM);
      wr(A_SSRC, 32'h000, OK);
      settle;
      check(sel[11:10], `AICS_CK_PLLA);
      wr(A_CLK, 32'h054, OK);
      settle;
      check(sel[3:2], `AICS_CK_PLLA);
      check(sel[11:10], `AICS_CK_PLLB);
      wr(A_CLK, 32'h010, OK);
    end
  endtask

  task t_rate;
    begin
      wr(A_PSRC, 32'h000, OK);
      wr(A_PORT, 32'h005, OK);
      wr(A_TSRC, 32'h001, OK);
      for (k = 0; k < 7; k = k + 1) begin
        wr(A_ADC, k << 5, OK);
        repeat (2) @(negedge aclk);
        check(ratio, RATIOS[11*k +: 11]);
      end
      check(aref, `AICS_REF_RATIO);
      check(tref, `AICS_REF_RATIO);
      settle;
      check(sel[9:8], `AICS_CK_PLLA);
      wr(A_SSRC, 32'h080, OK);
      settle;
      check(aref, `AICS_REF_SEC);
      check(tref, `AICS_REF_RATIO);
      wr(A_PSRC, 32'h080, OK);
      for (k = 0; k < 4; k = k + 1) begin
        wr(A_TSRC, k, OK);
        repeat (2) @(negedge aclk);
        check(tref, TREFS[3*k +: 3]);
      end
      check(aref, `AICS_REF_PTX);
    end
  endtask

  task t_dac;
    begin
      wr(A_DSRC, 32'h000, OK);
      settle;
      check(pd, 1'b1);
      check(dref, `AICS_REF_SFRM);
      check(sel[1:0], `AICS_CK_PLLA);
      wr(A_DCK, 32'h100, OK);
      repeat (2) @(negedge aclk);
      check(pd, 1'b0);
      check(dref, `AICS_REF_PRX);
      wr(A_DSRC, 32'h100, OK);
      repeat (2) @(negedge aclk);
      check(dref, `AICS_REF_SEC);
      rd(A_DCK, 32'h100, OK);
    end
  endtask

  task t_master;
    begin
      wr(A_CLK, 32'h01C, OK);
      wr(A_PORT, 32'h00E, OK);
      settle;
      check({rxsel, prx_gen, ptx_gen, sec_gen, bclk_rx}, 6'h1E);
      wr(A_PORT, 32'h000, OK);
      settle;
      check({prx_gen, ptx_gen, sec_gen, bclk_rx}, 4'h1);
    end
  endtask

  // Unmapped place, a wide write and the read-only status word
  task t_bus;
    begin
      wr(8'hFC, 32'h1FF, ERR);
      rd(8'hFC, 32'h000, ERR);
      wr(A_SEC, 32'hFFFFFFFF, OK);
      rd(A_SEC, 32'h1FF, OK);
      wr(A_STAT, 32'h000, OK);
    end
  endtask

  initial begin
    n_fail = 0;
    total_checks = 0;
    cyc = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_adc;
    t_rate;
    t_dac;
    t_master;
    t_bus;
    end_sim;
  end
endmodule
